// file: logic/phc_packet_config.sv
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/100ps
module phc_packet_config
   import phc_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [DATA_W-1:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [DATA_W-1:0] readdata,
   output logic waitrequest,
   input wire phc_rx_t rxIn,
   input wire logic standby,
   output phc_cfg_t cfg,
   output logic fifoWrValid,
   output logic [7:0] fifoWrData,
   output logic fifoClear,
   output logic fifoHostWrite,
   output logic fifoHostRead,
   output logic irq
);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic addrAccepted(input logic [1:0] mode, input logic [7:0] a,
                                         input logic [7:0] node);
      phc_filter_t m;
      m = phc_filter_t'(mode);
      case (m)
         FILT_OFF: addrAccepted = 1'b1;
         FILT_NODE: addrAccepted = (a == node);
         FILT_NODE_ZERO: addrAccepted = (a == node) || (a == BCAST_ZERO);
         FILT_NODE_ZERO_ONES: begin
            addrAccepted = (a == node) || (a == BCAST_ZERO) || (a == BCAST_ONES);
         end
         default: addrAccepted = 1'b0;
      endcase
   endfunction

   function automatic logic [7:0] regIndex(input logic [ADDR_W-1:0] a);
      regIndex = a[9:2];
   endfunction

   // ****************************************
   // Bus handshake
   // ****************************************
   phc_bus_t busState_ff;
   phc_bus_t nxt_busState;
   logic request;
   logic wrTake;
   logic rdTake;
   logic [7:0] idx;

   assign request = read | write;
   assign idx = regIndex(address);
   // One wait state so read data come from a flop
   assign waitrequest = request & (busState_ff == BUS_IDLE);
   assign wrTake = write & (busState_ff == BUS_ACK) & byteenable[0];
   assign rdTake = read & (busState_ff == BUS_ACK);

   always_comb begin
      case (busState_ff)
         BUS_IDLE: nxt_busState = request ? BUS_ACK : BUS_IDLE;
         BUS_ACK: nxt_busState = BUS_IDLE;
         default: nxt_busState = BUS_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         busState_ff <= BUS_IDLE;
      end else begin
         busState_ff <= nxt_busState;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   logic [7:0] pktFmt_ff;
   logic [7:0] fifoCrc_ff;
   logic [7:0] payLen_ff;
   logic [7:0] nodeAddr_ff;
   logic crcOk_ff;
   logic [3:0] irqStat_ff;
   logic [3:0] irqMask_ff;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pktFmt_ff <= RST_PACKET_FORMAT;
         fifoCrc_ff <= RST_FIFO_CRC;
         payLen_ff <= RST_PAYLOAD_LENGTH;
         nodeAddr_ff <= RST_NODE_ADDRESS;
         irqMask_ff <= RST_IRQ;
      end else if (wrTake) begin
         case (idx)
            IDX_PACKET_FORMAT: pktFmt_ff <= writedata[7:0];
            // Reserved bits dropped, so a careless host write cannot set them
            IDX_FIFO_CRC: fifoCrc_ff <= writedata[7:0] & MASK_FIFO_CRC;
            IDX_PAYLOAD_LENGTH: payLen_ff <= writedata[7:0] & MASK_PAYLOAD_LENGTH;
            IDX_NODE_ADDRESS: nodeAddr_ff <= writedata[7:0];
            IDX_IRQ_MASK: irqMask_ff <= writedata[3:0];
            default: ;
         endcase
      end
   end

   // Decoded controls
   logic lenVar;
   logic crcEn;
   logic autoClrDis;
   logic [1:0] filtMode;

   assign lenVar = pktFmt_ff[BIT_LENGTH_FORMAT];
   assign crcEn = pktFmt_ff[BIT_CRC_EN];
   assign autoClrDis = fifoCrc_ff[BIT_AUTOCLR_DIS];
   assign filtMode = pktFmt_ff[BIT_FILT_HI:BIT_FILT_LO];

   always_comb begin
      cfg.lengthVariable = lenVar;
      cfg.preambleBytes = {1'b0, pktFmt_ff[BIT_PRE_HI:BIT_PRE_LO]} + 3'h1;
      cfg.whitenEnable = pktFmt_ff[BIT_WHITEN];
      cfg.crcEnable = crcEn;
      cfg.txPayloadLength = lenVar ? 7'h00 : payLen_ff[6:0];
      cfg.rxMaxLength = payLen_ff[6:0];
   end

   // ****************************************
   // Receive filtering and FIFO feed
   // ****************************************
   logic pass_ff;
   logic addrOk;
   logic addrReject;
   logic lenReject;
   logic crcFail;

   assign addrOk = addrAccepted(filtMode, rxIn.addr, nodeAddr_ff);
   assign addrReject = rxIn.addrValid & ~addrOk;
   // Variable format: length is only an upper bound on receive
   assign lenReject = rxIn.lenValid & lenVar & (rxIn.len > payLen_ff[6:0]);
   assign crcFail = rxIn.crcDone & crcEn & ~rxIn.crcGood;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pass_ff <= 1'b0;
      end else if (rxIn.start) begin
         pass_ff <= 1'b1;
      end else if (addrReject || lenReject || rxIn.finish) begin
         pass_ff <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         fifoWrValid <= 1'b0;
         fifoWrData <= 8'h00;
      end else begin
         fifoWrValid <= rxIn.byteValid & pass_ff & ~addrReject & ~lenReject;
         fifoWrData <= rxIn.data;
      end
   end

   // ****************************************
   // CRC status and FIFO clear
   // ****************************************
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         crcOk_ff <= 1'b0;
      end else if (rxIn.crcDone && crcEn) begin
         crcOk_ff <= rxIn.crcGood;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         fifoClear <= 1'b0;
      end else begin
         fifoClear <= crcFail & ~autoClrDis;
      end
   end

   // Standby access direction, no access outside standby
   assign fifoHostWrite = standby & ~fifoCrc_ff[BIT_FIFO_DIR];
   assign fifoHostRead = standby & fifoCrc_ff[BIT_FIFO_DIR];

   // ****************************************
   // Interrupts
   // ****************************************
   logic [3:0] irqEvent;
   logic statRead;

   assign irqEvent[IRQ_CRC_OK] = rxIn.crcDone & crcEn & rxIn.crcGood;
   assign irqEvent[IRQ_CRC_FAIL] = crcFail;
   assign irqEvent[IRQ_ADDR_REJECT] = addrReject;
   assign irqEvent[IRQ_LEN_REJECT] = lenReject;
   assign statRead = rdTake & (idx == IDX_IRQ_STATUS);

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         irqStat_ff <= RST_IRQ;
      end else begin
         // Clear only what the read returned; a later event stays pending
         // A new event in the clearing cycle always wins over the clear
         irqStat_ff <= (irqStat_ff & ~(statRead ? readdata[3:0] : 4'h0)) | irqEvent;
      end
   end

   assign irq = |(irqStat_ff & irqMask_ff);

   // ****************************************
   // Read data
   // ****************************************
   logic [7:0] rdMux;

   always_comb begin
      case (idx)
         IDX_PACKET_FORMAT: rdMux = {pktFmt_ff[7:1], crcOk_ff};
         IDX_FIFO_CRC: rdMux = fifoCrc_ff;
         IDX_PAYLOAD_LENGTH: rdMux = payLen_ff;
         IDX_NODE_ADDRESS: rdMux = nodeAddr_ff;
         IDX_IRQ_STATUS: rdMux = {4'h0, irqStat_ff};
         IDX_IRQ_MASK: rdMux = {4'h0, irqMask_ff};
         default: rdMux = 8'h00;
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         readdata <= 32'h0000_0000;
      end else if (read && busState_ff == BUS_IDLE) begin
         readdata <= {24'h00_0000, rdMux};
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   a_filter_node_only: assert property (
      rxIn.addrValid && filtMode == FILT_NODE && rxIn.addr != nodeAddr_ff |=> !pass_ff)
      else $error("node filter let a foreign address through");

   a_filter_zero_ok: assert property (
      rxIn.addrValid && filtMode == FILT_NODE_ZERO && rxIn.addr == BCAST_ZERO
      && !rxIn.finish && !lenReject && !rxIn.start && pass_ff |=> pass_ff)
      else $error("zero address rejected in mode two");

   a_filter_ones_mode: assert property (
      rxIn.addrValid && rxIn.addr == BCAST_ONES && rxIn.addr != nodeAddr_ff
      |-> addrOk == (filtMode == FILT_NODE_ZERO_ONES || filtMode == FILT_OFF))
      else $error("all-ones address handled wrongly");

   a_filter_off_pass: assert property (
      rxIn.addrValid && filtMode == FILT_OFF |-> !addrReject)
      else $error("address rejected with filtering off");

   a_reject_no_fifo: assert property (
      addrReject ##1 !rxIn.start [*2] |-> !fifoWrValid ##1 !fifoWrValid)
      else $error("rejected packet wrote to fifo");

   a_len_reject: assert property (
      rxIn.lenValid && lenVar && rxIn.len > payLen_ff[6:0] && !rxIn.start
      |=> !pass_ff)
      else $error("over-long packet not rejected");

   a_fixed_no_len: assert property (
      !lenVar |-> !lenReject)
      else $error("length rejection in fixed format");

   a_fifo_byte: assert property (
      fifoWrValid |-> $past(rxIn.byteValid && pass_ff) && fifoWrData == $past(rxIn.data))
      else $error("fifo write without an accepted byte");

   a_crc_status: assert property (
      rxIn.crcDone && crcEn |=> crcOk_ff == $past(rxIn.crcGood))
      else $error("crc status not updated");

   a_crc_hold: assert property (
      !(rxIn.crcDone && crcEn) |=> $stable(crcOk_ff))
      else $error("crc status changed without a checked packet");

   a_autoclear: assert property (
      crcFail |=> fifoClear == !$past(autoClrDis))
      else $error("fifo clear wrong after crc failure");

   a_no_clear_crc_off: assert property (
      rxIn.crcDone && !crcEn |=> !fifoClear)
      else $error("fifo cleared while crc disabled");

   a_clear_cause: assert property (
      fifoClear |-> $past(crcFail) && !$past(autoClrDis))
      else $error("fifo cleared without a crc failure");

   a_fifo_dir: assert property (
      fifoHostRead |-> standby && !fifoHostWrite && fifoCrc_ff[BIT_FIFO_DIR])
      else $error("fifo direction wrong");

   a_no_standby: assert property (
      !standby |-> !fifoHostWrite && !fifoHostRead)
      else $error("host fifo access outside standby");

   a_preamble_len: assert property (
      wrTake && idx == IDX_PACKET_FORMAT
      |=> cfg.preambleBytes == $past(writedata[BIT_PRE_HI:BIT_PRE_LO]) + 3'h1)
      else $error("preamble byte count wrong");

   a_tx_length: assert property (
      lenVar |-> cfg.txPayloadLength == 7'h00 && cfg.rxMaxLength == payLen_ff[6:0])
      else $error("variable length misuse of payload length");

   a_wait_one: assert property (
      request && busState_ff == BUS_IDLE |=> !waitrequest || !request)
      else $error("bus wait longer than one cycle");

   a_reserved_zero: assert property (
      wrTake && idx == IDX_FIFO_CRC |=> fifoCrc_ff[5:0] == 6'h00)
      else $error("reserved bits stored");

   a_format_write: assert property (
      wrTake && idx == IDX_PACKET_FORMAT |=> cfg.lengthVariable
      == $past(writedata[BIT_LENGTH_FORMAT]) && cfg.crcEnable == $past(writedata[BIT_CRC_EN]))
      else $error("format or crc control not taken from write");

   a_whiten_follow: assert property (
      wrTake && idx == IDX_PACKET_FORMAT |=> cfg.whitenEnable == $past(writedata[BIT_WHITEN]))
      else $error("whitening control not taken from write");

   a_node_write: assert property (
      wrTake && idx == IDX_NODE_ADDRESS |=> nodeAddr_ff == $past(writedata[7:0]))
      else $error("node address not written");

   a_set_wins: assert property (
      irqEvent != 4'h0 |=> (irqStat_ff & $past(irqEvent)) == $past(irqEvent))
      else $error("status event lost");

   // ****************************************
   // Coverage of the main scenarios
   // ****************************************
   c_addr_reject: cover property (addrReject ##1 irqStat_ff[IRQ_ADDR_REJECT]);
   c_len_reject: cover property (lenReject ##1 irqStat_ff[IRQ_LEN_REJECT]);
   c_crc_clear: cover property (crcFail ##1 fifoClear);
   c_bcast_ones: cover property (rxIn.addrValid && addrOk && rxIn.addr == BCAST_ONES);
   c_status_read: cover property (statRead && irqStat_ff != 4'h0);

endmodule

// file: inc/phc_pkg.sv
// Functional notes
// - Length format bit 0 means fixed packets, 1 means variable; resets to 0.
// - Preamble size field gives 1 to 4 transmitted bytes; resets to three bytes.
// - Whitening and dewhitening run only while whitening enable is 1; resets off.
// - CRC calculated on transmit, checked on receive while CRC enable is 1 (reset).
// - Filter mode 00 accepts all; 01 accepts only the node address.
// - Filter mode 10 accepts node address or 0x00, rejects the rest.
// - Filter mode 11 accepts node address, 0x00 or 0xff, rejects the rest.
// - Read-only status bit shows current packet CRC result, 1 good, 0 bad.
// - FIFO cleared on CRC failure unless auto-clear disable bit is 1.
// - In standby, direction bit 0 gives host FIFO write access, 1 read.
// - Payload length is max receive length when variable, fixed length otherwise.
// - Received addresses compare against host-set node address, reset zero.
package phc_pkg;

   // ****************************************
   // Register indices, byte address is four times index
   // ****************************************
   localparam logic [7:0] IDX_PAYLOAD_LENGTH = 8'h1c;
   localparam logic [7:0] IDX_NODE_ADDRESS = 8'h1d;
   localparam logic [7:0] IDX_PACKET_FORMAT = 8'h1e;
   localparam logic [7:0] IDX_FIFO_CRC = 8'h1f;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;

   // ****************************************
   // Reset values and fields
   // ****************************************
   localparam logic [7:0] RST_PACKET_FORMAT = 8'h48;
   localparam logic [7:0] RST_FIFO_CRC = 8'h00;
   localparam logic [7:0] RST_PAYLOAD_LENGTH = 8'h00;
   localparam logic [7:0] RST_NODE_ADDRESS = 8'h00;
   localparam logic [3:0] RST_IRQ = 4'h0;
   localparam int BIT_LENGTH_FORMAT = 7;
   localparam int BIT_PRE_HI = 6;
   localparam int BIT_PRE_LO = 5;
   localparam int BIT_WHITEN = 4;
   localparam int BIT_CRC_EN = 3;
   localparam int BIT_FILT_HI = 2;
   localparam int BIT_FILT_LO = 1;
   localparam int BIT_CRC_OK = 0;
   localparam int BIT_AUTOCLR_DIS = 7;
   localparam int BIT_FIFO_DIR = 6;
   localparam logic [7:0] MASK_FIFO_CRC = 8'hc0;
   localparam logic [7:0] MASK_PAYLOAD_LENGTH = 8'h7f;
   localparam logic [7:0] BCAST_ZERO = 8'h00;
   localparam logic [7:0] BCAST_ONES = 8'hff;
   localparam int IRQ_CRC_OK = 0;
   localparam int IRQ_CRC_FAIL = 1;
   localparam int IRQ_ADDR_REJECT = 2;
   localparam int IRQ_LEN_REJECT = 3;

   typedef enum logic [1:0] {
      FILT_OFF = 2'b00,
      FILT_NODE = 2'b01,
      FILT_NODE_ZERO = 2'b10,
      FILT_NODE_ZERO_ONES = 2'b11
   } phc_filter_t;

   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_ACK = 1'b1
   } phc_bus_t;

   typedef struct packed {
      logic lengthVariable;
      logic [2:0] preambleBytes;
      logic whitenEnable;
      logic crcEnable;
      logic [6:0] txPayloadLength;
      logic [6:0] rxMaxLength;
   } phc_cfg_t;

   typedef struct packed {
      logic start;
      logic addrValid;
      logic [7:0] addr;
      logic lenValid;
      logic [6:0] len;
      logic byteValid;
      logic [7:0] data;
      logic crcDone;
      logic crcGood;
      logic finish;
   } phc_rx_t;

endpackage

// file: tb/phc_rx_source.sv
`timescale 1ns/100ps
module phc_rx_source
   import phc_pkg::*;
(
   output phc_rx_t rxOut,
   input wire logic clock
);
   // ******
   // Receive stream model
   // ******
   initial begin
      rxOut = '0;
   end

   task automatic step(input phc_rx_t r);
      @(posedge clock);
      rxOut <= r;
   endtask

   // Idle addr, len and data carry the inverse of the last value, never a stale copy; crcGood is 0 until crcDone, then inverted
   task automatic send_pkt(input logic [7:0] a, input logic [6:0] l, input logic [7:0] d,
                           input logic g);
      phc_rx_t r;
      r = '0;
      r.addr = ~a;
      r.len = ~l;
      r.data = ~d;
      r.start = 1'h1;
      step(r);
      r.start = 1'h0;
      r.addrValid = 1'h1;
      r.addr = a;
      step(r);
      r.addrValid = 1'h0;
      r.addr = ~a;
      r.lenValid = 1'h1;
      r.len = l;
      step(r);
      r.lenValid = 1'h0;
      r.len = ~l;
      r.byteValid = 1'h1;
      r.data = d;
      step(r);
      r.byteValid = 1'h0;
      r.data = ~d;
      r.crcDone = 1'h1;
      r.crcGood = g;
      step(r);
      r.crcDone = 1'h0;
      r.crcGood = ~g;
      r.finish = 1'h1;
      step(r);
      r.finish = 1'h0;
      step(r);
   endtask
endmodule

// file: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top
   import phc_pkg::*;
;
   logic clock = 1'h0;
   logic rst_b = 1'h0;
   logic [ADDR_W-1:0] address = '0;
   logic read = 1'h0;
   logic write = 1'h0;
   logic [DATA_W-1:0] writedata = '0;
   logic [3:0] byteenable = 4'h0;
   logic [DATA_W-1:0] readdata;
   logic waitrequest;
   phc_rx_t rxIn;
   logic standby = 1'h0;
   phc_cfg_t cfg;
   logic fifoWrValid, fifoClear, fifoHostWrite, fifoHostRead, irq;
   logic [7:0] fifoWrData;
   logic [7:0] lastData;
   int nFail = 0;
   int totalChecks = 0;
   int nWr = 0;
   int nClr = 0;

   always #50 clock = ~clock;

   phc_packet_config u_phc_packet_config (.clock(clock), .rst_b(rst_b),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .rxIn(rxIn), .standby(standby), .cfg(cfg), .fifoWrValid(fifoWrValid),
      .fifoWrData(fifoWrData), .fifoClear(fifoClear), .fifoHostWrite(fifoHostWrite),
      .fifoHostRead(fifoHostRead), .irq(irq));
   phc_rx_source u_phc_rx_source (.rxOut(rxIn), .clock(clock));

   always @(posedge clock) begin
      if (fifoWrValid === 1'h1) begin
         nWr <= nWr + 1;
         lastData <= fifoWrData;
      end
      if (fifoClear === 1'h1) begin
         nClr <= nClr + 1;
      end
   end

   // ******
   // Checks and bus access
   // ******
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      totalChecks++;
      if (got !== exp) begin
         nFail++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      chk8({7'h0, got}, {7'h0, exp});
   endtask

   // Latency checked to be exactly two cycles; only the watchdog ends a wait that never finishes
   task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] d,
                      input logic [3:0] be, output logic [7:0] q);
      int n;
      @(posedge clock);
      address <= {idx, 2'h0};
      read <= ~wr;
      write <= wr;
      writedata <= {24'h0, d};
      byteenable <= be;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (waitrequest !== 1'h0);
      q = readdata[7:0];
      read <= 1'h0;
      write <= 1'h0;
      chk8(8'(n), 8'h02);
      @(negedge clock);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] q;
      bus(idx, 1'h1, d, 4'h1, q);
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      bus(idx, 1'h0, 8'h00, 4'h0, q);
      chk8(q, exp);
   endtask

   task automatic pkt(input logic [7:0] a, input logic [6:0] l, input logic [7:0] d,
                      input logic g);
      u_phc_rx_source.send_pkt(a, l, d, g);
      @(negedge clock);
   endtask

   function automatic logic accept(input logic [1:0] m, input logic [7:0] a);
      accept = m == 2'h0 || a == 8'h5a || (m[1] && a == 8'h00) || (m == 2'h3 && a == 8'hff);
   endfunction

   task automatic end_test(input string s);
      $display("test %s done", s);
   endtask

   task automatic finishTest();
      $display("checks %0d mismatches %0d", totalChecks, nFail);
      if (nFail == 0 && totalChecks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ******
   // Test sequence
   // ******
   initial begin
      logic [7:0] q;
      logic [7:0] adr [4];
      int w;
      adr = '{8'h5a, 8'h00, 8'hff, 8'h33};
      repeat (6) @(posedge clock);
      rst_b <= 1'h1;
      rd_chk(IDX_PACKET_FORMAT, 8'h48);
      rd_chk(IDX_FIFO_CRC, 8'h00);
      rd_chk(IDX_NODE_ADDRESS, 8'h00);
      chk8({5'h0, cfg.preambleBytes}, 8'h03);
      chk1(cfg.lengthVariable, 1'h0);
      chk1(cfg.whitenEnable, 1'h0);
      chk1(cfg.crcEnable, 1'h1);
      wr(8'h3f, 8'hff);
      rd_chk(8'h3f, 8'h00);
      end_test("reset");
      for (int p = 0; p < 4; p++) begin
         wr(IDX_PACKET_FORMAT, {1'h0, p[1:0], p[0], p[1], 3'h0});
         chk8({5'h0, cfg.preambleBytes}, 8'(p + 1));
         chk1(cfg.whitenEnable, p[0]);
         chk1(cfg.crcEnable, p[1]);
      end
      wr(IDX_PAYLOAD_LENGTH, 8'h25);
      wr(IDX_PACKET_FORMAT, 8'hc8);
      chk1(cfg.lengthVariable, 1'h1);
      chk8({1'h0, cfg.txPayloadLength}, 8'h00);
      chk8({1'h0, cfg.rxMaxLength}, 8'h25);
      wr(IDX_PACKET_FORMAT, 8'h48);
      chk8({1'h0, cfg.txPayloadLength}, 8'h25);
      end_test("config");
      wr(IDX_NODE_ADDRESS, 8'h5a);
      bus(IDX_NODE_ADDRESS, 1'h1, 8'hff, 4'h0, q);
      rd_chk(IDX_NODE_ADDRESS, 8'h5a);
      for (int m = 0; m < 4; m++) begin
         wr(IDX_PACKET_FORMAT, {5'h09, m[1:0], 1'h0});
         for (int i = 0; i < 4; i++) begin
            w = nWr;
            pkt(adr[i], 7'h01, adr[i] ^ 8'h81, 1'h1);
            chk8(8'(nWr - w), {7'h0, accept(m[1:0], adr[i])});
         end
      end
      chk8(lastData, 8'h7e);
      end_test("filter");
      wr(IDX_PACKET_FORMAT, 8'h48);
      rd_chk(IDX_IRQ_STATUS, 8'h05);
      pkt(8'h11, 7'h01, 8'h22, 1'h1);
      rd_chk(IDX_PACKET_FORMAT, 8'h49);
      w = nClr;
      pkt(8'h11, 7'h01, 8'h22, 1'h0);
      chk8(8'(nClr - w), 8'h01);
      rd_chk(IDX_PACKET_FORMAT, 8'h48);
      chk1(irq, 1'h0);
      wr(IDX_IRQ_MASK, 8'h02);
      chk1(irq, 1'h1);
      rd_chk(IDX_IRQ_STATUS, 8'h03);
      chk1(irq, 1'h0);
      wr(IDX_FIFO_CRC, 8'h80);
      w = nClr;
      pkt(8'h11, 7'h01, 8'h22, 1'h0);
      chk8(8'(nClr - w), 8'h00);
      chk1(irq, 1'h1);
      wr(IDX_FIFO_CRC, 8'h00);
      wr(IDX_PACKET_FORMAT, 8'h40);
      rd_chk(IDX_IRQ_STATUS, 8'h02);
      w = nClr;
      pkt(8'h11, 7'h01, 8'h22, 1'h0);
      chk8(8'(nClr - w), 8'h00);
      rd_chk(IDX_IRQ_STATUS, 8'h00);
      end_test("crc");
      wr(IDX_PACKET_FORMAT, 8'hc8);
      w = nWr;
      pkt(8'h11, 7'h26, 8'h33, 1'h1);
      chk8(8'(nWr - w), 8'h00);
      rd_chk(IDX_IRQ_STATUS, 8'h09);
      pkt(8'h11, 7'h25, 8'h44, 1'h1);
      chk8(8'(nWr - w), 8'h01);
      chk8(lastData, 8'h44);
      rd_chk(IDX_IRQ_STATUS, 8'h01);
      end_test("length");
      chk1(fifoHostWrite, 1'h0);
      chk1(fifoHostRead, 1'h0);
      @(posedge clock);
      standby <= 1'h1;
      @(negedge clock);
      chk1(fifoHostWrite, 1'h1);
      chk1(fifoHostRead, 1'h0);
      wr(IDX_FIFO_CRC, 8'h40);
      chk1(fifoHostWrite, 1'h0);
      chk1(fifoHostRead, 1'h1);
      rd_chk(IDX_FIFO_CRC, 8'h40);
      end_test("fifo access");
      finishTest();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clock);
      nFail++;
      $display("unexpected at %0t: watchdog expired", $time);
      finishTest();
   end
endmodule
